/* hw/qos_pkg.sv */
package qos_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WEIGHT = 8'h04;
	localparam logic [7:0] ADDR_PCP = 8'h08;
	localparam logic [7:0] ADDR_DSCP0 = 8'h10;
	localparam logic [7:0] ADDR_DSCP1 = 8'h14;
	localparam logic [7:0] ADDR_DSCP2 = 8'h18;
	localparam logic [7:0] ADDR_DSCP3 = 8'h1c;
	localparam logic [7:0] ADDR_STATUS = 8'h20;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_STRICT_BIT = 2;
	localparam int CTRL_JUMBO_BIT = 3;
	localparam int CTRL_BULKQ_LSB = 4;
	localparam int CTRL_BULK_BIT = 6;
	localparam int STATUS_DROP_LSB = 16;
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_PCP = 2'h1;
	localparam logic [1:0] MODE_DSCP = 2'h2;
	localparam logic [1:0] MODE_BAD = 2'h3;
	localparam logic [1:0] Q_LOW = 2'h0;
	localparam logic [1:0] Q_NORMAL = 2'h1;
	localparam logic [1:0] Q_MEDIUM = 2'h2;
	localparam logic [1:0] Q_HIGH = 2'h3;
	localparam logic [2:0] PCP_UNTAGGED = 3'h0;
	localparam logic [15:0] WEIGHT_RST = 16'h8421;
	localparam logic [15:0] PCP_RST = 16'hfa41;
	localparam logic STRICT_RST = 1'b0;
	localparam logic [1:0] MODE_RST = MODE_OFF;

	function automatic logic [127:0] dscp_default();
		logic [127:0] r;
		logic [1:0] q;
		r = '0;
		for (int i = 0; i < 64; i++) begin
			q = Q_NORMAL;
			if (i % 2 == 0 && i >= 8 && i <= 16) q = Q_LOW;
			if (i % 2 == 0 && i >= 26 && i <= 42) q = Q_MEDIUM;
			if (i == 46 || i == 48 || i == 56) q = Q_HIGH;
			r[2*i +: 2] = q;
		end
		return r;
	endfunction : dscp_default

	localparam logic [127:0] DSCP_RST = dscp_default();
endpackage : qos_pkg

/* hw/qos_sched.sv */
`timescale 1ns/1ps
`default_nettype none
module qos_sched (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [3:0] nonempty_i,
	input wire logic wrr_i,
	input wire logic [15:0] weights_i,
	input wire logic take_i,
	output logic valid_o,
	output logic [1:0] sel_o
);
	typedef struct packed {
		logic [1:0] cur;
		logic [3:0] cnt;
	} sch_t;
	sch_t s;
	sch_t next_s;

	// zero weight would starve a queue forever, so it counts as one
	function automatic logic [3:0] wt(logic [15:0] w, logic [1:0] q);
		logic [3:0] v;
		v = w[{q, 2'h0} +: 4];
		return (v == 4'h0) ? 4'h1 : v;
	endfunction : wt

	function automatic logic [1:0] highest(logic [3:0] ne);
		logic [1:0] h;
		h = 2'h0;
		for (int k = 0; k < 4; k++) begin
			if (ne[k]) h = 2'(k);
		end
		return h;
	endfunction : highest

	function automatic logic [1:0] next_lower(logic [3:0] ne, logic [1:0] from);
		logic [1:0] r;
		logic [1:0] q;
		logic found;
		r = from;
		found = 1'b0;
		for (int k = 1; k <= 4; k++) begin
			q = from - 2'(k);
			if (ne[q] && !found) begin
				r = q;
				found = 1'b1;
			end
		end
		return r;
	endfunction : next_lower

	always_comb begin
		next_s = s;
		valid_o = |nonempty_i;
		if (!wrr_i) begin
			sel_o = highest(nonempty_i);
		end else if (nonempty_i[s.cur] && s.cnt < wt(weights_i, s.cur)) begin
			sel_o = s.cur;
		end else begin
			sel_o = next_lower(nonempty_i, s.cur);
		end
		if (take_i) begin
			if (sel_o == s.cur && s.cnt < wt(weights_i, s.cur)) begin
				next_s.cnt = s.cnt + 4'h1;
			end else begin
				next_s.cur = sel_o;
				next_s.cnt = 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : qos_sched
`default_nettype wire

/* hw/qos_classify_queue_sched.sv */
`timescale 1ns/1ps
`default_nettype none
module qos_classify_queue_sched #(
	parameter int DEPTH = 16,
	parameter int IDW = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic in_valid_i,
	input wire logic [IDW-1:0] in_id_i,
	input wire logic in_ipv4_i,
	input wire logic in_tagged_i,
	input wire logic [2:0] in_pcp_i,
	input wire logic [5:0] in_dscp_i,
	output logic drop_o,
	input wire logic out_ready_i,
	output logic out_valid_o,
	output logic [IDW-1:0] out_id_o,
	output logic [1:0] out_queue_o
);
	localparam int AW = $clog2(DEPTH);
	localparam int TW = AW + 3;
	localparam int CTRL_MODE_LSB_W = qos_pkg::CTRL_MODE_LSB;

	typedef struct packed {
		logic wb_ack;
		logic [31:0] wb_dat;
		logic [1:0] mode;
		logic strict_sel;
		logic jumbo;
		logic [15:0] weights;
		logic [15:0] pcp_map;
		logic [127:0] dscp_map;
		logic [3:0][DEPTH-1:0][IDW-1:0] mem;
		logic [3:0][AW-1:0] rd;
		logic [3:0][AW-1:0] wr;
		logic [3:0][AW:0] cnt;
		logic out_valid;
		logic [IDW-1:0] out_id;
		logic [1:0] out_queue;
		logic drop;
		logic [15:0] drop_cnt;
	} st_t;

	st_t s;
	st_t next_s;
	logic [3:0] nonempty;
	logic sch_valid;
	logic [1:0] sch_sel;
	logic pop;

	function automatic logic [31:0] wb_merge(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction : wb_merge

	// occupancy ceiling per class: lower classes hit their ceiling first
	function automatic logic [TW-1:0] adm_limit(logic [1:0] q);
		return TW'((int'(q) + 2) * DEPTH);
	endfunction : adm_limit

	function automatic logic [31:0] ctrl_read(st_t t);
		logic [31:0] r;
		r = '0;
		r[CTRL_MODE_LSB_W +: 2] = t.mode;
		r[qos_pkg::CTRL_STRICT_BIT] = t.strict_sel;
		r[qos_pkg::CTRL_JUMBO_BIT] = t.jumbo;
		return r;
	endfunction : ctrl_read

	always_comb begin
		for (int k = 0; k < 4; k++) begin
			nonempty[k] = (s.cnt[k] != '0);
		end
		pop = sch_valid && (!s.out_valid || out_ready_i);
	end

	qos_sched sched (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.nonempty_i(nonempty),
		.wrr_i(!s.strict_sel),
		.weights_i(s.weights),
		.take_i(pop),
		.valid_o(sch_valid),
		.sel_o(sch_sel)
	);

	always_comb begin
		logic [31:0] w;
		logic [1:0] cls;
		logic [1:0] bq;
		logic [2:0] pcp;
		logic [TW-1:0] total;
		logic [1:0] nmode;
		w = '0;
		cls = qos_pkg::Q_NORMAL;
		bq = '0;
		pcp = '0;
		nmode = '0;
		next_s = s;
		next_s.wb_ack = 1'b0;
		next_s.drop = 1'b0;

		// register slave: one wait state, unmapped reads give zero
		if (wb_cyc_i && wb_stb_i && !s.wb_ack) begin
			next_s.wb_ack = 1'b1;
			case (wb_adr_i)
				qos_pkg::ADDR_CTRL: next_s.wb_dat = ctrl_read(s);
				qos_pkg::ADDR_WEIGHT: next_s.wb_dat = {16'h0000, s.weights};
				qos_pkg::ADDR_PCP: next_s.wb_dat = {16'h0000, s.pcp_map};
				qos_pkg::ADDR_DSCP0: next_s.wb_dat = s.dscp_map[31:0];
				qos_pkg::ADDR_DSCP1: next_s.wb_dat = s.dscp_map[63:32];
				qos_pkg::ADDR_DSCP2: next_s.wb_dat = s.dscp_map[95:64];
				qos_pkg::ADDR_DSCP3: next_s.wb_dat = s.dscp_map[127:96];
				qos_pkg::ADDR_STATUS: begin
					next_s.wb_dat = '0;
					next_s.wb_dat[3:0] = nonempty;
					next_s.wb_dat[qos_pkg::STATUS_DROP_LSB +: 16] = s.drop_cnt;
				end
				default: next_s.wb_dat = '0;
			endcase
			if (wb_we_i) begin
				case (wb_adr_i)
					qos_pkg::ADDR_CTRL: begin
						w = wb_merge(ctrl_read(s), wb_dat_i, wb_sel_i);
						nmode = w[CTRL_MODE_LSB_W +: 2];
						if (nmode != qos_pkg::MODE_BAD) next_s.mode = nmode;
						next_s.jumbo = w[qos_pkg::CTRL_JUMBO_BIT];
						// wrr refused while jumbo frames are on
						next_s.strict_sel = w[qos_pkg::CTRL_STRICT_BIT]
							| w[qos_pkg::CTRL_JUMBO_BIT];
						bq = w[qos_pkg::CTRL_BULKQ_LSB +: 2];
						if (wb_sel_i[0] && w[qos_pkg::CTRL_BULK_BIT]) begin
							if (next_s.mode == qos_pkg::MODE_PCP) begin
								next_s.pcp_map = {8{bq}};
							end else if (next_s.mode == qos_pkg::MODE_DSCP) begin
								next_s.dscp_map = {64{bq}};
							end
						end
					end
					qos_pkg::ADDR_WEIGHT: begin
						w = wb_merge({16'h0000, s.weights}, wb_dat_i, wb_sel_i);
						next_s.weights = w[15:0];
					end
					qos_pkg::ADDR_PCP: begin
						w = wb_merge({16'h0000, s.pcp_map}, wb_dat_i, wb_sel_i);
						next_s.pcp_map = w[15:0];
					end
					qos_pkg::ADDR_DSCP0: next_s.dscp_map[31:0] =
						wb_merge(s.dscp_map[31:0], wb_dat_i, wb_sel_i);
					qos_pkg::ADDR_DSCP1: next_s.dscp_map[63:32] =
						wb_merge(s.dscp_map[63:32], wb_dat_i, wb_sel_i);
					qos_pkg::ADDR_DSCP2: next_s.dscp_map[95:64] =
						wb_merge(s.dscp_map[95:64], wb_dat_i, wb_sel_i);
					qos_pkg::ADDR_DSCP3: next_s.dscp_map[127:96] =
						wb_merge(s.dscp_map[127:96], wb_dat_i, wb_sel_i);
					default: next_s.wb_dat = '0;
				endcase
			end
		end

		// classification, with the tables as they stood before this cycle
		pcp = in_tagged_i ? in_pcp_i : qos_pkg::PCP_UNTAGGED;
		case (s.mode)
			qos_pkg::MODE_OFF: cls = qos_pkg::Q_NORMAL;
			qos_pkg::MODE_PCP: begin
				if (in_ipv4_i) cls = s.pcp_map[{pcp, 1'b0} +: 2];
				else cls = qos_pkg::Q_NORMAL;
			end
			qos_pkg::MODE_DSCP: begin
				if (in_ipv4_i) cls = s.dscp_map[{in_dscp_i, 1'b0} +: 2];
				else cls = qos_pkg::Q_NORMAL;
			end
			default: cls = qos_pkg::Q_NORMAL;
		endcase

		// admission: a full queue or a busy switch drops low classes first
		total = TW'(s.cnt[0]) + TW'(s.cnt[1]) + TW'(s.cnt[2]) + TW'(s.cnt[3]);
		if (in_valid_i) begin
			if (s.cnt[cls] != (AW+1)'(DEPTH) && total < adm_limit(cls)) begin
				next_s.mem[cls][s.wr[cls]] = in_id_i;
				next_s.wr[cls] = s.wr[cls] + AW'(1);
				next_s.cnt[cls] = s.cnt[cls] + (AW+1)'(1);
			end else begin
				next_s.drop = 1'b1;
				if (s.drop_cnt != 16'hffff) next_s.drop_cnt = s.drop_cnt + 16'h0001;
			end
		end

		// egress stage; a full queue refuses even if it drains this cycle
		if (pop) begin
			next_s.out_valid = 1'b1;
			next_s.out_queue = sch_sel;
			next_s.out_id = s.mem[sch_sel][s.rd[sch_sel]];
			next_s.rd[sch_sel] = s.rd[sch_sel] + AW'(1);
			next_s.cnt[sch_sel] = next_s.cnt[sch_sel] - (AW+1)'(1);
		end else if (out_ready_i) begin
			next_s.out_valid = 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s <= '0;
			s.mode <= qos_pkg::MODE_RST;
			s.strict_sel <= qos_pkg::STRICT_RST;
			s.weights <= qos_pkg::WEIGHT_RST;
			s.pcp_map <= qos_pkg::PCP_RST;
			s.dscp_map <= qos_pkg::DSCP_RST;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		wb_ack_o = s.wb_ack;
		wb_dat_o = s.wb_dat;
		drop_o = s.drop;
		out_valid_o = s.out_valid;
		out_id_o = s.out_id;
		out_queue_o = s.out_queue;
	end
endmodule : qos_classify_queue_sched
`default_nettype wire

/* verif/qos_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module qos_monitor #(
	parameter int IDW = 16
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic in_valid_i,
	input wire logic drop_o,
	input wire logic out_ready_i,
	input wire logic out_valid_o,
	input wire logic [IDW-1:0] out_id_o,
	input wire logic [1:0] out_queue_o
);
	logic rc;
	assign rc = wb_ack_o && !wb_we_i && wb_adr_i == qos_pkg::ADDR_CTRL;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_pulse: assert property (p_pulse) else $error("ack too long");
	property p_mode; rc |-> wb_dat_o[1:0] != qos_pkg::MODE_BAD; endproperty
	a_mode: assert property (p_mode) else $error("bad mode");
	property p_jumbo; rc && wb_dat_o[3] |-> wb_dat_o[2]; endproperty
	a_jumbo: assert property (p_jumbo) else $error("wrr with jumbo");
	property p_bulk; rc |-> !wb_dat_o[6]; endproperty
	a_bulk: assert property (p_bulk) else $error("bulk reads set");
	property p_drop; drop_o |-> $past(in_valid_i); endproperty
	a_drop: assert property (p_drop) else $error("drop without frame");
	property p_hold;
		out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_id_o) && $stable(out_queue_o);
	endproperty
	a_hold: assert property (p_hold) else $error("egress not held");
	property p_rise; $rose(out_valid_o) |-> $past(in_valid_i) || $past(in_valid_i, 2); endproperty
	a_rise: assert property (p_rise) else $error("egress from nothing");
	c_drop: cover property (drop_o);
	c_take: cover property (out_valid_o && out_ready_i);
	c_strict: cover property (rc && wb_dat_o[2]);
endmodule : qos_monitor
bind qos_classify_queue_sched qos_monitor #(.IDW(IDW)) mon_u (.clk_i, .rstn_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .in_valid_i, .drop_o,
	.out_ready_i, .out_valid_o, .out_id_o, .out_queue_o);
`default_nettype wire

/* verif/egress_sink.sv */
`timescale 1ns/1ps
`default_nettype none
module egress_sink (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic en_i,
	input wire logic slow_i,
	output logic ready_o
);
	// random stalls exercise the hold path
	always_ff @(posedge clk_i or negedge rstn_i)
		if (!rstn_i) ready_o <= 1'b0;
		else ready_o <= en_i && (!slow_i || $urandom % 2 == 0);
endmodule : egress_sink
`default_nettype wire

/* verif/qos_classify_queue_sched_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module qos_classify_queue_sched_tb;
	localparam int D = 16;
	logic clk_i = 1'b0, rstn_i = 1'b0, cyc = 1'b0, we = 1'b0, iv = 1'b0, v4 = 1'b0, tg = 1'b0;
	logic en = 1'b0, slow = 1'b0, ack, drop, ov, rdy;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, dat, rdat, x;
	logic [2:0] pcp = 3'h0;
	logic [5:0] dscp = 6'h00;
	logic [15:0] id = 16'h0, oid;
	logic [1:0] oq, sq, pt[8], dt[64];
	logic [3:0] w[4];
	int errors = 0, comparisons = 0, cycles = 0, drops, cur, cnt, sid, mode, strict, nid = 0;
	bit sv;
	int mq[4][$];
	qos_classify_queue_sched #(.DEPTH(D), .IDW(16)) dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
		.wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .in_valid_i(iv), .in_id_i(id),
		.in_ipv4_i(v4), .in_tagged_i(tg), .in_pcp_i(pcp), .in_dscp_i(dscp), .drop_o(drop),
		.out_ready_i(rdy), .out_valid_o(ov), .out_id_o(oid), .out_queue_o(oq));
	egress_sink snk_u (.clk_i(clk_i), .rstn_i(rstn_i), .en_i(en), .slow_i(slow), .ready_o(rdy));
	initial forever #2 clk_i = ~clk_i;
	task automatic results();
		if (errors == 0 && comparisons > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, s, e);
		end
	endtask : chk
	// no fixed latency assumed: wait on ack, timeout ends a hang
	task automatic wb(input logic w_, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{cyc, we, adr, wd} <= {1'b1, w_, a, d};
		do @(posedge clk_i); while (ack !== 1'b1);
		rdat = dat;
		cyc <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask : rd
	function automatic logic [31:0] pk(input int b, input bit p);
		pk = 32'h0;
		for (int k = 0; k < 16; k++) if (!p || k < 8) pk[2*k +: 2] = p ? pt[k] : dt[b+k];
	endfunction : pk
	function automatic logic [1:0] cls(input bit ip, input bit t, input logic [2:0] p,
		input logic [5:0] d);
		if (!ip || mode == 0) return 2'h1;
		if (mode == 1) return pt[t ? p : 3'h0];
		return dt[d];
	endfunction : cls
	function automatic void pop();
		int q;
		sv = mq[0].size() + mq[1].size() + mq[2].size() + mq[3].size() > 0;
		if (!sv) return;
		if (strict) begin
			q = 3;
			while (mq[q].size() == 0) q--;
		end else begin
			if (cnt >= (w[cur] == 4'h0 ? 1 : w[cur]) || mq[cur].size() == 0) begin
				cnt = 0;
				do cur = (cur + 3) % 4; while (mq[cur].size() == 0);
			end
			q = cur;
			cnt++;
		end
		sid = mq[q].pop_front();
		sq = 2'(q);
	endfunction : pop
	task automatic rst();
		rstn_i <= 1'b0;
		repeat (10) @(posedge clk_i);
		rstn_i <= 1'b1;
		{drops, cur, cnt, sv, mode, strict} = '0;
		foreach (mq[i]) mq[i].delete();
		pt = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
		w = '{4'h1, 4'h2, 4'h4, 4'h8};
		for (int i = 0; i < 64; i++)
			dt[i] = i inside {46, 48, 56} ? 2'h3 :
				i % 2 || i < 8 || i > 42 || (i > 16 && i < 26) ? 2'h1 : i < 26 ? 2'h0 : 2'h2;
	endtask : rst
	task automatic send();
		logic [31:0] r;
		logic [1:0] q;
		bit e;
		r = $urandom;
		nid++;
		q = cls(r[11:10] != 2'h0, r[9], r[8:6], r[5:0]);
		e = mq[q].size() >= D || (q < 2'h3 &&
			mq[0].size() + mq[1].size() + mq[2].size() + mq[3].size() >= (q + 2) * D);
		@(posedge clk_i);
		{iv, v4, tg, pcp, dscp, id} <= {1'b1, r[11:10] != 2'h0, r[9:0], nid[15:0]};
		@(posedge clk_i);
		iv <= 1'b0;
		@(posedge clk_i);
		chk(32'(drop), 32'(e));
		if (!e) mq[q].push_back(nid);
		drops += e;
		if (!sv) pop();
	endtask : send
	always @(posedge clk_i) begin
		cycles++;
		if (rstn_i && ov && rdy) begin
			chk({14'h0, oq, oid}, {14'h0, sq, sid[15:0]});
			pop();
		end
		if (cycles == 8000) begin
			errors++;
			results();
		end
	end
	initial begin
		void'($urandom(32'h393b));
		rst();
		rd(qos_pkg::ADDR_CTRL, 32'h0);
		rd(qos_pkg::ADDR_WEIGHT, 32'h8421);
		rd(qos_pkg::ADDR_PCP, pk(0, 1'b1));
		for (int j = 0; j < 4; j++) rd(qos_pkg::ADDR_DSCP0 + 8'(4 * j), pk(16 * j, 1'b0));
		rd(8'h0c, 32'h0);
		wb(1'b1, qos_pkg::ADDR_CTRL, 32'h9);
		rd(qos_pkg::ADDR_CTRL, 32'hd);
		wb(1'b1, qos_pkg::ADDR_CTRL, 32'h2);
		wb(1'b1, qos_pkg::ADDR_CTRL, 32'h3);
		rd(qos_pkg::ADDR_CTRL, 32'h2);
		for (int c = 0; c < 8; c++) begin
			rst();
			mode = c == 6 ? 1 : c == 7 ? 2 : c % 3;
			strict = c == 3 || c == 4;
			if (c >= 3) begin
				x = $urandom;
				wb(1'b1, qos_pkg::ADDR_PCP, x);
				for (int k = 0; k < 8; k++) pt[k] = x[2*k +: 2];
				for (int j = 0; j < 4; j++) begin
					x = $urandom;
					wb(1'b1, qos_pkg::ADDR_DSCP0 + 8'(4 * j), x);
					for (int k = 0; k < 16; k++) dt[16*j+k] = x[2*k +: 2];
				end
			end
			if (c >= 5) begin
				x = $urandom;
				wb(1'b1, qos_pkg::ADDR_WEIGHT, x);
				for (int k = 0; k < 4; k++) w[k] = x[4*k +: 4];
			end
			x = $urandom & 32'h30 | 32'(c == 4 || c == 7) << 6 | 32'(strict) << 2 | 32'(mode);
			wb(1'b1, qos_pkg::ADDR_CTRL, x);
			if (c == 4) for (int k = 0; k < 8; k++) pt[k] = x[5:4];
			if (c == 7) for (int k = 0; k < 64; k++) dt[k] = x[5:4];
			slow = c % 2;
			// enough frames to push the total past the low-class ceiling
			repeat (48) send();
			en <= 1'b1;
			for (int k = 0; k < 500 && (sv || ov); k++) @(posedge clk_i);
			chk(32'(ov), 32'h0);
			en <= 1'b0;
			rd(qos_pkg::ADDR_STATUS, {drops[15:0], 16'h0});
		end
		results();
	end
endmodule : qos_classify_queue_sched_tb
`default_nettype wire
